// ### inc/sync_ctrl_pkg.sv
// shared constants and types for the synchronizer mode control link
package sync_ctrl_pkg;

  // clock and reset timing
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned RESET_MIN_NS   = 300;
  // strictly longer than the minimum, hence the extra cycle
  localparam int unsigned RESET_CYCLES   = RESET_MIN_NS / CLK_PERIOD_NS + 1;
  localparam int unsigned GUARD_TIME_MS  = 1000;
  localparam int unsigned GUARD_CYCLES   = GUARD_TIME_MS * (1000000 / CLK_PERIOD_NS);

  // phase step limits in ns and capture range sum in ppm
  localparam logic [7:0] PHASE_TO_HOLD_NS = 8'd50;
  localparam logic [7:0] PHASE_TO_NORM_NS = 8'd200;
  localparam logic [8:0] CAPTURE_SUM_PPM  = 9'd230;

  // mode select pin encoding {high, low}
  localparam logic [1:0] SEL_NORMAL   = 2'h0;
  localparam logic [1:0] SEL_HOLDOVER = 2'h1;
  localparam logic [1:0] SEL_FREERUN  = 2'h2;
  localparam logic [1:0] SEL_AUTO     = 2'h3;

  // device operating mode, one-hot
  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b001,
    MODE_HOLDOVER = 3'b010,
    MODE_FREERUN  = 3'b100
  } op_mode_t;

  // controller register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_GUARD  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // control register fields
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_REF_BIT  = 2;
  localparam int unsigned CTRL_TIE_BIT  = 3;
  localparam int unsigned CTRL_CLR_BIT  = 4;
  localparam int unsigned CTRL_RST_BIT  = 5;
  localparam logic [3:0]  CTRL_RESET    = 4'h3;

endpackage

// ### inc/sync_link_if.sv
// pin level link between the mode controller and the synchronizer device
`timescale 1ns/1ns
`default_nettype none
interface sync_link_if;
  logic primary_loss;
  logic secondary_loss;
  logic guard_time_in;
  logic mode_select_low;
  logic mode_select_high;
  logic reference_choice;
  logic phase_error_clear;
  logic reset_n;
  logic holdover_ind;

  modport device (
    input  primary_loss, secondary_loss, guard_time_in, mode_select_low,
           mode_select_high, reference_choice, phase_error_clear, reset_n,
    output holdover_ind
  );

  modport controller (
    output primary_loss, secondary_loss, guard_time_in, mode_select_low,
           mode_select_high, reference_choice, phase_error_clear, reset_n,
    input  holdover_ind
  );
endinterface
`default_nettype wire

// ### hw/sync_mode_device.sv
// synchronizer device end: automatic and manual mode and reference control
// Behaviour
// - primary lost, guard running: enter holdover
// - guard expired, secondary good: secondary normal
// - primary recovered: back to primary normal
// - early recovery: normal again, same reference
// - manual: mode pins pick normal/holdover/freerun
// - manual: reference pin picks primary or secondary
// - manual: guard input enables correction
// - clear input realigns output phase
// - reset held low over 300 ns
// - keep correction off for short holdovers
// - correction off: realign on every recovery
// - freerun uses master source only
// - capture range plus master tolerance 230
// - phase steps 50 ns and 200 ns
// - holdover keeps stored locked frequency
// - outside supplies 20 MHz master source; here the master clock has an 8 ns period (125 MHz)
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module sync_mode_device (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // pin link
  sync_link_if.device      link,
  // loop side
  input  wire logic [31:0] loop_freq_i,
  input  wire logic [7:0]  master_tol_ppm_i,
  // status to loop and output stages
  output logic [2:0]       mode_o,
  output logic             ref_secondary_o,
  output logic             realign_o,
  output logic             tie_correct_o,
  output logic             master_only_o,
  output logic [7:0]       phase_limit_ns_o,
  output logic [8:0]       capture_ppm_o,
  output logic [31:0]      freq_word_o
);

  // registered state and its next values
  sync_ctrl_pkg::op_mode_t mode_reg, mode_next;
  logic        ref_sec_reg, ref_sec_next;
  logic        realign_reg, realign_next;
  logic        tie_reg, tie_next;
  logic        master_reg, master_next;
  logic [7:0]  limit_reg, limit_next;
  logic [8:0]  capture_reg, capture_next;
  logic [31:0] freq_reg, freq_next;
  logic        hold_ind_reg, hold_ind_next;
  logic [1:0]  sel;
  logic        recovering;
  logic        tie_allowed;

  // mode select pins as one code, 11 is automatic
  assign sel = {link.mode_select_high, link.mode_select_low};

  // next mode and reference; the reset pin forces freerun on the primary synchronously
  always_comb begin
    mode_next    = mode_reg;
    ref_sec_next = ref_sec_reg;
    if (!link.reset_n) begin
      // device reset wins over every mode request
      mode_next    = sync_ctrl_pkg::MODE_FREERUN;
      ref_sec_next = 1'b0;
    end else if (sel == sync_ctrl_pkg::SEL_AUTO) begin
      case (mode_reg)
        sync_ctrl_pkg::MODE_NORMAL: begin
          if (!ref_sec_reg && link.primary_loss) begin
            mode_next = sync_ctrl_pkg::MODE_HOLDOVER;
          end else if (ref_sec_reg && !link.primary_loss) begin
            ref_sec_next = 1'b0;
          end else if (ref_sec_reg && link.secondary_loss) begin
            // both references lost: hold on the secondary
            mode_next = sync_ctrl_pkg::MODE_HOLDOVER;
          end
        end
        sync_ctrl_pkg::MODE_HOLDOVER: begin
          if (!link.primary_loss) begin
            mode_next    = sync_ctrl_pkg::MODE_NORMAL;
            ref_sec_next = 1'b0;
          end else if (link.guard_time_in && !link.secondary_loss) begin
            // guard expired with the secondary usable
            mode_next    = sync_ctrl_pkg::MODE_NORMAL;
            ref_sec_next = 1'b1;
          end
        end
        default: begin
          // leaving freerun under automatic control starts on the primary
          mode_next    = link.primary_loss ? sync_ctrl_pkg::MODE_HOLDOVER : sync_ctrl_pkg::MODE_NORMAL;
          ref_sec_next = 1'b0;
        end
      endcase
    end else begin
      // manual control: the mode pins decide directly
      case (sel)
        sync_ctrl_pkg::SEL_NORMAL:   mode_next = sync_ctrl_pkg::MODE_NORMAL;
        sync_ctrl_pkg::SEL_HOLDOVER: mode_next = sync_ctrl_pkg::MODE_HOLDOVER;
        default:                     mode_next = sync_ctrl_pkg::MODE_FREERUN;
      endcase
      ref_sec_next = link.reference_choice;
    end
  end

  // holdover to normal is the only change that needs a phase decision
  assign recovering = (mode_reg == sync_ctrl_pkg::MODE_HOLDOVER) && (mode_next == sync_ctrl_pkg::MODE_NORMAL);

  // manual correction only applies to primary holdover back to primary normal
  assign tie_allowed = (sel != sync_ctrl_pkg::SEL_AUTO) && link.guard_time_in && !ref_sec_reg && !ref_sec_next;

  // phase pulses; automatic control never keeps accumulated offset
  always_comb begin
    realign_next = 1'b0;
    tie_next     = 1'b0;
    if (link.reset_n && recovering) begin
      if (tie_allowed) begin
        tie_next = 1'b1;
      end else begin
        realign_next = 1'b1;
      end
    end
    // a clear in the same cycle as a correction still realigns
    if (link.reset_n && link.phase_error_clear) begin
      realign_next = 1'b1;
    end
  end

  // mode derived figures and the frequency hold
  always_comb begin
    limit_next    = limit_reg;
    freq_next     = freq_reg;
    master_next   = (mode_next == sync_ctrl_pkg::MODE_FREERUN);
    hold_ind_next = (mode_next == sync_ctrl_pkg::MODE_HOLDOVER);
    // the limit reflects the most recent mode change only
    if (mode_next != mode_reg) begin
      if (mode_next == sync_ctrl_pkg::MODE_HOLDOVER) begin
        limit_next = sync_ctrl_pkg::PHASE_TO_HOLD_NS;
      end else begin
        limit_next = sync_ctrl_pkg::PHASE_TO_NORM_NS;
      end
    end
    // the stored value is only refreshed while locked in normal mode
    if (!link.reset_n) begin
      freq_next = 32'h0;
    end else if (mode_reg == sync_ctrl_pkg::MODE_NORMAL && mode_next == sync_ctrl_pkg::MODE_NORMAL) begin
      freq_next = loop_freq_i;
    end else if (mode_reg == sync_ctrl_pkg::MODE_FREERUN) begin
      freq_next = 32'h0;
    end // holdover keeps freq_reg untouched
    // saturate so a poor master source gives zero capture, never a wrap
    if ({1'b0, master_tol_ppm_i} >= sync_ctrl_pkg::CAPTURE_SUM_PPM) begin
      capture_next = 9'h0;
    end else begin
      capture_next = sync_ctrl_pkg::CAPTURE_SUM_PPM - {1'b0, master_tol_ppm_i};
    end
  end

  // mode and reference state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg    <= sync_ctrl_pkg::MODE_FREERUN;
      ref_sec_reg <= 1'b0;
    end else begin
      mode_reg    <= mode_next;
      ref_sec_reg <= ref_sec_next;
    end
  end

  // one-cycle phase pulses
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      realign_reg <= 1'b0;
      tie_reg     <= 1'b0;
    end else begin
      realign_reg <= realign_next;
      tie_reg     <= tie_next;
    end
  end

  // derived figures; reset leaves the loop in freerun on the master source
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      master_reg   <= 1'b1;
      limit_reg    <= 8'h0;
      capture_reg  <= sync_ctrl_pkg::CAPTURE_SUM_PPM;
      freq_reg     <= 32'h0;
      hold_ind_reg <= 1'b0;
    end else begin
      master_reg   <= master_next;
      limit_reg    <= limit_next;
      capture_reg  <= capture_next;
      freq_reg     <= freq_next;
      hold_ind_reg <= hold_ind_next;
    end
  end

  // every output comes straight from a register
  assign mode_o            = mode_reg;
  assign ref_secondary_o   = ref_sec_reg;
  assign realign_o         = realign_reg;
  assign tie_correct_o     = tie_reg;
  assign master_only_o     = master_reg;
  assign phase_limit_ns_o  = limit_reg;
  assign capture_ppm_o     = capture_reg;
  assign freq_word_o       = freq_reg;
  assign link.holdover_ind = hold_ind_reg;

endmodule
`default_nettype wire

// ### hw/sync_mode_controller.sv
// mode controller end: apb registers, guard timer, reset and clear pulses
`timescale 1ns/1ns
`default_nettype none
module sync_mode_controller #(
  parameter int unsigned GUARD_DEFAULT = sync_ctrl_pkg::GUARD_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // line interface loss flags
  input  wire logic        line_primary_loss_i,
  input  wire logic        line_secondary_loss_i,
  // pin link
  sync_link_if.controller  link
);

  logic [3:0]  ctrl_reg, ctrl_next;
  logic [31:0] guard_reg, guard_next;
  logic [31:0] gcnt_reg, gcnt_next;
  logic        gexp_reg, gexp_next;
  logic [5:0]  rcnt_reg, rcnt_next;
  logic        clr_reg, clr_next;
  logic        ploss_reg, ploss_next;
  logic        sloss_reg, sloss_next;
  logic        ready_reg, ready_next;
  logic        err_reg, err_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        access, commit, mapped, wr;
  logic        auto_mode;

  assign access    = psel_i && penable_i;
  assign commit    = access && ready_reg;
  assign wr        = commit && pwrite_i && mapped;
  assign mapped    = (paddr_i == sync_ctrl_pkg::OFS_CTRL) || (paddr_i == sync_ctrl_pkg::OFS_GUARD) ||
                     (paddr_i == sync_ctrl_pkg::OFS_STATUS);
  // taken from the next control value so the guard pin changes meaning with the mode pins
  assign auto_mode = (ctrl_next[1:0] == sync_ctrl_pkg::SEL_AUTO);

  // apb: one wait state, read data and error registered with ready
  always_comb begin
    ready_next = access && !ready_reg;
    err_next   = access && !ready_reg && !mapped;
    rdata_next = 32'h0;
    if (access && !ready_reg && !pwrite_i) begin
      case (paddr_i)
        sync_ctrl_pkg::OFS_CTRL:   rdata_next = {28'h0, ctrl_reg};
        sync_ctrl_pkg::OFS_GUARD:  rdata_next = guard_reg;
        sync_ctrl_pkg::OFS_STATUS: rdata_next = {27'h0, (rcnt_reg != 6'h0), link.holdover_ind,
                                                 gexp_reg, sloss_reg, ploss_reg};
        default:                   rdata_next = 32'h0;
      endcase
    end
  end

  // control writes, reset stretch and clear pulse
  always_comb begin
    ctrl_next  = ctrl_reg;
    guard_next = guard_reg;
    clr_next   = 1'b0;
    rcnt_next  = (rcnt_reg != 6'h0) ? rcnt_reg - 6'h1 : 6'h0;
    if (wr && paddr_i == sync_ctrl_pkg::OFS_CTRL) begin
      ctrl_next = pwdata_i[sync_ctrl_pkg::CTRL_TIE_BIT:sync_ctrl_pkg::CTRL_SEL_LSB];
      clr_next  = pwdata_i[sync_ctrl_pkg::CTRL_CLR_BIT];
      if (pwdata_i[sync_ctrl_pkg::CTRL_RST_BIT]) begin
        rcnt_next = 6'(sync_ctrl_pkg::RESET_CYCLES);
      end
    end
    if (wr && paddr_i == sync_ctrl_pkg::OFS_GUARD) begin
      guard_next = pwdata_i;
    end
  end

  // guard timer: low while counting after a primary loss, high once expired
  always_comb begin
    ploss_next = line_primary_loss_i;
    sloss_next = line_secondary_loss_i;
    gcnt_next  = 32'h0;
    gexp_next  = 1'b0;
    if (line_primary_loss_i && ploss_reg) begin
      gexp_next = (gcnt_reg >= guard_reg);
      gcnt_next = gexp_next ? gcnt_reg : gcnt_reg + 32'h1;
    end
  end

  // registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg  <= sync_ctrl_pkg::CTRL_RESET;
      guard_reg <= GUARD_DEFAULT;
      gcnt_reg  <= 32'h0;
      gexp_reg  <= 1'b0;
      rcnt_reg  <= 6'h0;
      clr_reg   <= 1'b0;
      ploss_reg <= 1'b0;
      sloss_reg <= 1'b0;
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ctrl_reg  <= ctrl_next;
      guard_reg <= guard_next;
      gcnt_reg  <= gcnt_next;
      gexp_reg  <= gexp_next;
      rcnt_reg  <= rcnt_next;
      clr_reg   <= clr_next;
      ploss_reg <= ploss_next;
      sloss_reg <= sloss_next;
      ready_reg <= ready_next;
      err_reg   <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  // pin drive: in manual mode the guard pin carries the correction enable
  logic gt_pin_reg;
  logic gt_pin_next;
  always_comb begin
    gt_pin_next = auto_mode ? gexp_next : ctrl_next[sync_ctrl_pkg::CTRL_TIE_BIT];
  end
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gt_pin_reg <= 1'b0;
    end else begin
      gt_pin_reg <= gt_pin_next;
    end
  end

  assign prdata_o               = rdata_reg;
  assign pready_o               = ready_reg;
  assign pslverr_o              = err_reg;
  assign link.primary_loss      = ploss_reg;
  assign link.secondary_loss    = sloss_reg;
  assign link.guard_time_in     = gt_pin_reg;
  assign link.mode_select_low   = ctrl_reg[sync_ctrl_pkg::CTRL_SEL_LSB];
  assign link.mode_select_high  = ctrl_reg[sync_ctrl_pkg::CTRL_SEL_LSB + 1];
  assign link.reference_choice  = ctrl_reg[sync_ctrl_pkg::CTRL_REF_BIT];
  assign link.phase_error_clear = clr_reg;
  assign link.reset_n           = (rcnt_reg == 6'h0);

endmodule
`default_nettype wire

// ### testbench/sync_mode_reference_control_assertions.sv
// concurrent checks on the pin link and the device mode outputs
`timescale 1ns/1ns
`default_nettype none
module sync_mode_reference_control_assertions (
  // clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  // link pins
  input wire logic       primary_loss,
  input wire logic       secondary_loss,
  input wire logic       guard_time_in,
  input wire logic       mode_select_low,
  input wire logic       mode_select_high,
  input wire logic       reference_choice,
  input wire logic       phase_error_clear,
  input wire logic       reset_n,
  // device outputs
  input wire logic [2:0] mode_o,
  input wire logic       ref_secondary_o,
  input wire logic       realign_o,
  input wire logic       tie_correct_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic       auto_sel;
  logic [2:0] man_mode;
  logic [7:0] low_cnt_reg;
  logic [7:0] low_cnt_next;
  // mode pin decode, 11 means automatic
  assign auto_sel = mode_select_high & mode_select_low;
  assign man_mode = mode_select_high ? sync_ctrl_pkg::MODE_FREERUN :
                    mode_select_low ? sync_ctrl_pkg::MODE_HOLDOVER : sync_ctrl_pkg::MODE_NORMAL;
  // counts low cycles of the device reset so its width can be judged at release
  always_comb low_cnt_next = reset_n ? 8'h00 : low_cnt_reg + 8'h01;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) low_cnt_reg <= 8'h00;
    else low_cnt_reg <= low_cnt_next;
  end
  a_loss_enters_hold: assert property (auto_sel && reset_n && primary_loss && !guard_time_in &&
    mode_o == sync_ctrl_pkg::MODE_NORMAL && !ref_secondary_o |=> mode_o == sync_ctrl_pkg::MODE_HOLDOVER &&
    !ref_secondary_o) else $error("primary loss did not give holdover on primary");
  a_guard_to_second: assert property (auto_sel && reset_n && primary_loss && guard_time_in && !secondary_loss &&
    mode_o == sync_ctrl_pkg::MODE_HOLDOVER |=> mode_o == sync_ctrl_pkg::MODE_NORMAL && ref_secondary_o)
    else $error("expired guard did not switch to secondary");
  a_primary_back: assert property (auto_sel && reset_n && !primary_loss |=>
    mode_o == sync_ctrl_pkg::MODE_NORMAL && !ref_secondary_o) else $error("no return to primary normal");
  a_leave_hold_realign: assert property (auto_sel && reset_n && !primary_loss &&
    mode_o == sync_ctrl_pkg::MODE_HOLDOVER |=> realign_o) else $error("no realign on leaving holdover");
  a_manual_mode: assert property (!auto_sel && reset_n |=> mode_o == $past(man_mode))
    else $error("manual mode not followed");
  a_manual_ref: assert property (!auto_sel && reset_n |=> ref_secondary_o == $past(reference_choice))
    else $error("manual reference not followed");
  a_tie_enable: assert property (!auto_sel && reset_n && man_mode == sync_ctrl_pkg::MODE_NORMAL &&
    !reference_choice && guard_time_in && mode_o == sync_ctrl_pkg::MODE_HOLDOVER && !ref_secondary_o
    |=> tie_correct_o) else $error("no correction pulse with guard pin high");
  a_clear_realign: assert property (phase_error_clear && reset_n |=> realign_o)
    else $error("clear did not realign");
  a_reset_freerun: assert property (!reset_n |=> mode_o == sync_ctrl_pkg::MODE_FREERUN)
    else $error("device reset did not force freerun");
  a_reset_width: assert property ($rose(reset_n) |-> low_cnt_reg == sync_ctrl_pkg::RESET_CYCLES)
    else $error("device reset width wrong");
  // main scenarios reached
  c_secondary: cover property (auto_sel && mode_o == sync_ctrl_pkg::MODE_NORMAL && ref_secondary_o);
  c_tie: cover property (tie_correct_o);
  c_dev_reset: cover property ($rose(reset_n));
endmodule
`default_nettype wire

// ### testbench/test_sync_mode_reference_control.sv
// self-checking bench: controller and device joined over the pin link
`timescale 1ns/1ns
`default_nettype none
module test_sync_mode_reference_control;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, lpl, lsl;
  logic [7:0]  paddr, tol;
  logic [31:0] pwdata, prdata, loop_freq, seed, r, g, freq;
  logic [2:0]  mode;
  logic        ref_sec, realign, time_interval_error, master_only;
  logic [7:0]  phase_lim;
  logic [8:0]  capture;
  logic [33:0] q[$];
  logic [33:0] e;
  int          miscompares, n_tests, cycles;
  sync_link_if sync_link_if_i ();
  sync_mode_controller #(.GUARD_DEFAULT(20)) sync_mode_controller_i (.ref_clk_i(ref_clk), .rst_i(rst),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .line_primary_loss_i(lpl), .line_secondary_loss_i(lsl),
    .link(sync_link_if_i.controller));
  sync_mode_device sync_mode_device_i (.ref_clk_i(ref_clk), .rst_i(rst), .link(sync_link_if_i.device),
    .loop_freq_i(loop_freq), .master_tol_ppm_i(tol), .mode_o(mode), .ref_secondary_o(ref_sec), .realign_o(realign),
    .tie_correct_o(time_interval_error), .master_only_o(master_only), .phase_limit_ns_o(phase_lim), .capture_ppm_o(capture),
    .freq_word_o(freq));
  sync_mode_reference_control_assertions sync_mode_reference_control_assertions_i (.ref_clk_i(ref_clk),
    .rst_i(rst), .primary_loss(sync_link_if_i.primary_loss), .secondary_loss(sync_link_if_i.secondary_loss),
    .guard_time_in(sync_link_if_i.guard_time_in), .mode_select_low(sync_link_if_i.mode_select_low),
    .mode_select_high(sync_link_if_i.mode_select_high), .reference_choice(sync_link_if_i.reference_choice),
    .phase_error_clear(sync_link_if_i.phase_error_clear), .reset_n(sync_link_if_i.reset_n), .mode_o(mode),
    .ref_secondary_o(ref_sec), .realign_o(realign), .tie_correct_o(time_interval_error));
  always #4 ref_clk = ~ref_clk; // master timing source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic print_verdict();
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    n_tests++;
    if (s !== x) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one transfer then an idle cycle, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic er, input logic [31:0] x);
    q.push_back({w, er, x});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // outputs are looked at on the falling edge where they are settled
  task automatic mode_is(input logic [2:0] m, input logic s);
    @(negedge ref_clk);
    chk("mode", 32'(m), 32'(mode));
    chk("reference", 32'(s), 32'(ref_sec));
    chk("phase limit", (m == sync_ctrl_pkg::MODE_HOLDOVER) ? 32'(sync_ctrl_pkg::PHASE_TO_HOLD_NS) :
        32'(sync_ctrl_pkg::PHASE_TO_NORM_NS), 32'(phase_lim));
    @(posedge ref_clk);
  endtask
  // answer monitor takes the oldest note at every completed transfer
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      chk("pslverr", 32'(e[32]), 32'(pslverr));
      if (!e[33]) chk("prdata", e[31:0], prdata);
    end
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    seed = 32'hf4cba0cd;
    {ref_clk, psel, penable, pwrite, lpl, lsl} = 6'h00;
    rst = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    loop_freq = xs();
    r = xs();
    tol = {1'b0, r[6:0]};
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    apb(0, sync_ctrl_pkg::OFS_CTRL, 32'h0, 0, 32'h3);
    apb(0, sync_ctrl_pkg::OFS_GUARD, 32'h0, 0, 32'd20);
    apb(0, sync_ctrl_pkg::OFS_STATUS, 32'h0, 0, 32'h0);
    apb(1, 8'h0c, r, 1, 32'h0);
    apb(0, 8'h0c, 32'h0, 1, 32'h0);
    g = (xs() & 32'h7) + 32'h10;
    apb(1, sync_ctrl_pkg::OFS_GUARD, g, 0, 32'h0);
    apb(0, sync_ctrl_pkg::OFS_GUARD, 32'h0, 0, g);
    @(negedge ref_clk);
    chk("capture", 32'd230 - 32'(tol), 32'(capture));
    chk("freq", loop_freq, freq);
    @(posedge ref_clk);
    lpl <= 1'b1;
    cyc(4);
    mode_is(sync_ctrl_pkg::MODE_HOLDOVER, 0);
    r = loop_freq;
    loop_freq <= xs();
    apb(0, sync_ctrl_pkg::OFS_STATUS, 32'h0, 0, 32'h9);
    @(negedge ref_clk);
    chk("held freq", r, freq);
    @(posedge ref_clk);
    lpl <= 1'b0;
    cyc(3);
    mode_is(sync_ctrl_pkg::MODE_NORMAL, 0);
    lpl <= 1'b1;
    cyc(int'(g) + 10);
    mode_is(sync_ctrl_pkg::MODE_NORMAL, 1);
    apb(0, sync_ctrl_pkg::OFS_STATUS, 32'h0, 0, 32'h5);
    lsl <= 1'b1;
    cyc(3);
    mode_is(sync_ctrl_pkg::MODE_HOLDOVER, 1);
    lpl <= 1'b0;
    lsl <= 1'b0;
    cyc(4);
    mode_is(sync_ctrl_pkg::MODE_NORMAL, 0);
    for (int m = 0; m < 3; m++) begin
      r = xs();
      apb(1, sync_ctrl_pkg::OFS_CTRL, {29'h0, r[0], 2'(m)}, 0, 32'h0);
      cyc(2);
      mode_is(3'(1 << m), r[0]);
    end
    @(negedge ref_clk);
    chk("master only", 32'h1, 32'(master_only));
    @(posedge ref_clk);
    apb(1, sync_ctrl_pkg::OFS_CTRL, 32'h9, 0, 32'h0);
    apb(1, sync_ctrl_pkg::OFS_CTRL, 32'h8, 0, 32'h0);
    @(negedge ref_clk);
    chk("tie correct", 32'h1, 32'(time_interval_error));
    chk("realign", 32'h0, 32'(realign));
    @(posedge ref_clk);
    apb(1, sync_ctrl_pkg::OFS_CTRL, 32'h10, 0, 32'h0);
    @(negedge ref_clk);
    chk("realign", 32'h1, 32'(realign));
    @(posedge ref_clk);
    apb(1, sync_ctrl_pkg::OFS_CTRL, 32'h23, 0, 32'h0);
    apb(0, sync_ctrl_pkg::OFS_STATUS, 32'h0, 0, 32'h10);
    mode_is(sync_ctrl_pkg::MODE_FREERUN, 0);
    cyc(50);
    apb(0, sync_ctrl_pkg::OFS_STATUS, 32'h0, 0, 32'h0);
    mode_is(sync_ctrl_pkg::MODE_NORMAL, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
